// ===== rtl/paging_tlb_pkg.sv
// package: constants, register map and carrier types for the paging translation block
package paging_tlb_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFF_TEST_COMMAND = 8'h00;
	localparam logic [7:0] OFF_TEST_DATA    = 8'h04;
	localparam logic [7:0] OFF_CONTROL      = 8'h08;
	localparam logic [7:0] OFF_DIR_BASE     = 8'h0c;
	localparam logic [7:0] OFF_CONFIG4      = 8'h10;
	localparam logic [7:0] OFF_INVALIDATE   = 8'h14;
	localparam logic [7:0] OFF_STATUS       = 8'h18;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_PROT_BIT   = 0;
	localparam int CTRL_PAGING_BIT = 31;
	localparam int CFG4_DIRC_BIT   = 4;
	localparam int ENT_PRESENT     = 0;
	localparam int ENT_WRITABLE    = 1;
	localparam int ENT_USER        = 2;
	localparam int ENT_WTHRU       = 3;
	localparam int ENT_NOCACHE     = 4;
	localparam int ENT_REF         = 5;
	localparam int ENT_MOD         = 6;
	localparam int CMD_VALID_BIT   = 11;
	localparam int DATA_HV_BIT     = 5;
	localparam int DATA_HD_BIT     = 4;
	localparam int DATA_HB_BIT     = 3;
	localparam int PAGE_BITS       = 12;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_DIRREQ = 7'b0000010,
		ST_DIRWT  = 7'b0000100,
		ST_PGREQ  = 7'b0001000,
		ST_PGWT   = 7'b0010000,
		ST_DONE   = 7'b0100000,
		ST_FAULT  = 7'b1000000
	} walk_state_e;

	// one cached page translation
	typedef struct packed {
		logic        valid;
		logic [19:0] linTag;
		logic [19:0] physPage;
		logic        nocache;
		logic        wthru;
		logic        modified;
		logic        user;
		logic        writable;
		logic        referenced;
	} tlb_entry_s;

	// directory entry cache line
	typedef struct packed {
		logic        valid;
		logic [9:0]  dirIndex;
		logic [19:0] tableBase;
	} dir_entry_s;

	// translation result toward the core
	typedef struct packed {
		logic [31:0] physAddr;
		logic        nocache;
		logic        wthru;
		logic        fault;
	} xlate_result_s;
endpackage : paging_tlb_pkg

// ===== rtl/paging_translation_tlb.sv
// module: linear to physical translation with directory cache, main and victim buffers
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module paging_translation_tlb #(
	parameter int MAIN_ENTRIES   = 128,
	parameter int VICTIM_ENTRIES = 8,
	parameter int DIR_ENTRIES    = 4
) (
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	input  wire logic                          xlateReq,
	input  wire logic [31:0]                   linearAddr,
	input  wire logic                          isWrite,
	input  wire logic [1:0]                    currentPrivilegeLevel,
	output logic                               xlateDone,
	output paging_tlb_pkg::xlate_result_s      xlateResult,
	output logic                               memReq,
	output logic [31:0]                        memAddr,
	input  wire logic                          memAck,
	input  wire logic [31:0]                   memData
);
	localparam int MI = $clog2(MAIN_ENTRIES);
	localparam int VI = $clog2(VICTIM_ENTRIES);
	localparam int DI = $clog2(DIR_ENTRIES);

	paging_tlb_pkg::tlb_entry_s mainTlb [MAIN_ENTRIES];
	paging_tlb_pkg::tlb_entry_s victimTlb [VICTIM_ENTRIES];
	paging_tlb_pkg::dir_entry_s dirCache [DIR_ENTRIES];
	logic [VI-1:0]              victimPtr;
	logic [DI-1:0]              dirPtr;
	logic [31:0]                testCommand;
	logic [31:0]                testData;
	logic [31:0]                controlReg;
	logic [31:0]                dirBase;
	logic [31:0]                config4;
	paging_tlb_pkg::walk_state_e state;
	logic [31:0]                reqAddr;
	logic                       reqWrite;
	logic [1:0]                 reqPriv;
	logic [19:0]                tableBase;
	logic                       walkFill;
	paging_tlb_pkg::tlb_entry_s fillEntry;

	// ****************************************
	// helpers
	// ****************************************
	// attribute pair match for test lookups
	function automatic logic pairMatch(input logic b, input logic bn, input logic v);
		pairMatch = (b && bn) || (b && !bn && v) || (!b && bn && !v);
	endfunction

	function automatic logic [MI-1:0] mainIndex(input logic [19:0] lin);
		mainIndex = lin[MI-1:0];
	endfunction

	// access check; privilege 3 needs user bit, writes need writable
	function automatic logic permitted(input paging_tlb_pkg::tlb_entry_s e,
		input logic wr, input logic [1:0] current_privilege_level);
		permitted = (e.user || current_privilege_level != 2'h3) && (e.writable || !wr);
	endfunction

	wire         pagingOn = controlReg[paging_tlb_pkg::CTRL_PAGING_BIT]
		&& controlReg[paging_tlb_pkg::CTRL_PROT_BIT];
	wire         dirCacheOn = config4[paging_tlb_pkg::CFG4_DIRC_BIT];
	wire [19:0]  reqPage = reqAddr[31:paging_tlb_pkg::PAGE_BITS];
	wire [9:0]   dirIdx = reqAddr[31:22];
	wire [9:0]   tblIdx = reqAddr[21:12];
	wire [MI-1:0] reqSlot = mainIndex(reqPage);
	wire         mainHit = mainTlb[reqSlot].valid && mainTlb[reqSlot].linTag == reqPage;

	logic          victimHit;
	logic [VI-1:0] victimIdx;
	logic          dirHit;
	logic [19:0]   dirHitBase;
	always_comb begin
		victimHit = 1'b0;
		victimIdx = '0;
		for (int i = 0; i < VICTIM_ENTRIES; i++) begin
			if (victimTlb[i].valid && victimTlb[i].linTag == reqPage) begin
				victimHit = 1'b1;
				victimIdx = VI'(i);
			end
		end
		dirHit = 1'b0;
		dirHitBase = '0;
		for (int i = 0; i < DIR_ENTRIES; i++) begin
			if (dirCacheOn && dirCache[i].valid && dirCache[i].dirIndex == dirIdx) begin
				dirHit = 1'b1;
				dirHitBase = dirCache[i].tableBase;
			end
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	wire apbWrite = psel && penable && pwrite;
	wire apbRead  = psel && penable && !pwrite;
	wire wrCmd    = apbWrite && paddr == paging_tlb_pkg::OFF_TEST_COMMAND;
	wire wrBase   = apbWrite && paddr == paging_tlb_pkg::OFF_DIR_BASE;
	wire wrInval  = apbWrite && paddr == paging_tlb_pkg::OFF_INVALIDATE;
	wire cmdDirect = wrCmd && !pwdata[0];
	wire cmdLookup = wrCmd && pwdata[2:0] == 3'h1;
	wire mapped   = paddr inside {paging_tlb_pkg::OFF_TEST_COMMAND, paging_tlb_pkg::OFF_TEST_DATA,
		paging_tlb_pkg::OFF_CONTROL, paging_tlb_pkg::OFF_DIR_BASE, paging_tlb_pkg::OFF_CONFIG4,
		paging_tlb_pkg::OFF_INVALIDATE, paging_tlb_pkg::OFF_STATUS};

	// single-cycle access phase: ready is a registered copy of the setup cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			prdata  <= paging_tlb_pkg::RST_WORD;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !mapped;
			case (paddr)
				paging_tlb_pkg::OFF_TEST_COMMAND: prdata <= testCommand;
				paging_tlb_pkg::OFF_TEST_DATA:    prdata <= testData;
				paging_tlb_pkg::OFF_CONTROL:      prdata <= controlReg;
				paging_tlb_pkg::OFF_DIR_BASE:     prdata <= dirBase;
				paging_tlb_pkg::OFF_CONFIG4:      prdata <= config4;
				paging_tlb_pkg::OFF_STATUS:       prdata <= {25'h0, state};
				default:                          prdata <= paging_tlb_pkg::RST_WORD;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			controlReg <= paging_tlb_pkg::RST_WORD;
			dirBase    <= paging_tlb_pkg::RST_WORD;
			config4    <= paging_tlb_pkg::RST_WORD;
		end else if (apbWrite) begin
			if (paddr == paging_tlb_pkg::OFF_CONTROL) controlReg <= pwdata;
			if (paddr == paging_tlb_pkg::OFF_DIR_BASE) dirBase <= {pwdata[31:12], 12'h000};
			if (paddr == paging_tlb_pkg::OFF_CONFIG4) config4 <= pwdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			testCommand <= paging_tlb_pkg::RST_WORD;
		end else if (wrCmd) begin
			testCommand <= pwdata;
		end
	end

	// ****************************************
	// test lookup and data register
	// ****************************************
	logic [VI:0]   lkVictimHits;
	logic [VI-1:0] lkVictimIdx;
	logic          lkMainHit;
	always_comb begin
		logic [19:0] lp;
		logic [MI-1:0] ls;
		lp = pwdata[31:12];
		ls = mainIndex(lp);
		lkVictimHits = '0;
		lkVictimIdx = '0;
		for (int i = 0; i < VICTIM_ENTRIES; i++) begin
			if (victimTlb[i].valid && victimTlb[i].linTag == lp
				&& pairMatch(pwdata[4], pwdata[3], victimTlb[i].referenced)) begin
				lkVictimHits = lkVictimHits + 1'b1;
				lkVictimIdx = VI'(i);
			end
		end
		lkMainHit = mainTlb[ls].valid && mainTlb[ls].linTag == lp
			&& pairMatch(pwdata[4], pwdata[3], mainTlb[ls].referenced);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			testData <= paging_tlb_pkg::RST_WORD;
		end else if (cmdLookup) begin
			testData[paging_tlb_pkg::DATA_HV_BIT] <= lkVictimHits != '0;
			testData[paging_tlb_pkg::DATA_HD_BIT] <= lkMainHit;
			testData[paging_tlb_pkg::DATA_HB_BIT] <= 1'b0;
			// with more than one hit the other fields are left as they were
			if (lkMainHit && lkVictimHits == '0) begin
				testData[31:12] <= mainTlb[mainIndex(pwdata[31:12])].physPage;
				testData[11]    <= mainTlb[mainIndex(pwdata[31:12])].nocache;
				testData[10]    <= mainTlb[mainIndex(pwdata[31:12])].wthru;
			end else if (!lkMainHit && lkVictimHits == 1) begin
				testData[31:12] <= victimTlb[lkVictimIdx].physPage;
				testData[11]    <= victimTlb[lkVictimIdx].nocache;
				testData[10]    <= victimTlb[lkVictimIdx].wthru;
				testData[9:7]   <= 3'(lkVictimIdx);
			end
		end else if (apbWrite && paddr == paging_tlb_pkg::OFF_TEST_DATA) begin
			testData <= pwdata;
		end
	end

	// ****************************************
	// table walk
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state     <= paging_tlb_pkg::ST_IDLE;
			reqAddr   <= paging_tlb_pkg::RST_WORD;
			reqWrite  <= 1'b0;
			reqPriv   <= 2'h0;
			tableBase <= 20'h0;
		end else begin
			case (state)
				paging_tlb_pkg::ST_IDLE: if (xlateReq) begin
					reqAddr  <= linearAddr;
					reqWrite <= isWrite;
					reqPriv  <= currentPrivilegeLevel;
					state    <= paging_tlb_pkg::ST_DONE;
					if (pagingOn) state <= paging_tlb_pkg::ST_DIRREQ;
				end
				paging_tlb_pkg::ST_DIRREQ: begin
					if (mainHit || victimHit) begin
						state <= paging_tlb_pkg::ST_DONE;
					end else if (dirHit) begin
						tableBase <= dirHitBase;
						state <= paging_tlb_pkg::ST_PGREQ;
					end else begin
						state <= paging_tlb_pkg::ST_DIRWT;
					end
				end
				paging_tlb_pkg::ST_DIRWT: if (memAck) begin
					tableBase <= memData[31:12];
					state <= memData[paging_tlb_pkg::ENT_PRESENT] ? paging_tlb_pkg::ST_PGREQ
						: paging_tlb_pkg::ST_FAULT;
				end
				paging_tlb_pkg::ST_PGREQ: state <= paging_tlb_pkg::ST_PGWT;
				paging_tlb_pkg::ST_PGWT: if (memAck) begin
					state <= memData[paging_tlb_pkg::ENT_PRESENT] ? paging_tlb_pkg::ST_DIRREQ
						: paging_tlb_pkg::ST_FAULT;
				end
				paging_tlb_pkg::ST_DONE: state <= paging_tlb_pkg::ST_IDLE;
				paging_tlb_pkg::ST_FAULT: begin
					state <= paging_tlb_pkg::ST_IDLE;
				end
				default: state <= paging_tlb_pkg::ST_IDLE;
			endcase
		end
	end

	assign walkFill = state == paging_tlb_pkg::ST_PGWT && memAck
		&& memData[paging_tlb_pkg::ENT_PRESENT];
	always_comb begin
		fillEntry = '0;
		if (cmdDirect) begin
			fillEntry.valid      = pwdata[paging_tlb_pkg::CMD_VALID_BIT];
			fillEntry.linTag     = pwdata[31:12];
			fillEntry.physPage   = testData[31:12];
			fillEntry.nocache    = testData[11];
			fillEntry.wthru      = testData[10];
			fillEntry.modified   = pwdata[10];
			fillEntry.user       = pwdata[8];
			fillEntry.writable   = pwdata[6];
			fillEntry.referenced = pwdata[4];
		end else begin
			fillEntry.valid      = 1'b1;
			fillEntry.linTag     = reqPage;
			fillEntry.physPage   = memData[31:12];
			fillEntry.nocache    = memData[paging_tlb_pkg::ENT_NOCACHE];
			fillEntry.wthru      = memData[paging_tlb_pkg::ENT_WTHRU];
			fillEntry.modified   = memData[paging_tlb_pkg::ENT_MOD];
			fillEntry.user       = memData[paging_tlb_pkg::ENT_USER];
			fillEntry.writable   = memData[paging_tlb_pkg::ENT_WRITABLE];
			fillEntry.referenced = memData[paging_tlb_pkg::ENT_REF];
		end
	end

	// ****************************************
	// buffer arrays: fill, evict, swap, flush
	// ****************************************
	wire          doFill = walkFill || cmdDirect;
	wire [MI-1:0] fillSlot = cmdDirect ? mainIndex(pwdata[31:12]) : reqSlot;
	wire          doSwap = state == paging_tlb_pkg::ST_DIRREQ && !mainHit && victimHit;
	wire [19:0]   invPage = pwdata[31:12];
	logic [VI-1:0] freeSlot;
	logic          haveFree;
	always_comb begin
		freeSlot = victimPtr;
		haveFree = 1'b0;
		for (int i = VICTIM_ENTRIES - 1; i >= 0; i--) begin
			if (!victimTlb[i].valid) begin
				freeSlot = VI'(i);
				haveFree = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || wrBase) begin
			for (int i = 0; i < MAIN_ENTRIES; i++) mainTlb[i] <= '0;
			for (int i = 0; i < VICTIM_ENTRIES; i++) victimTlb[i] <= '0;
			victimPtr <= '0;
		end else if (wrInval) begin
			if (mainTlb[mainIndex(invPage)].linTag == invPage) mainTlb[mainIndex(invPage)].valid <= 1'b0;
			for (int i = 0; i < VICTIM_ENTRIES; i++)
				if (victimTlb[i].linTag == invPage) victimTlb[i].valid <= 1'b0;
		end else if (doSwap) begin
			mainTlb[reqSlot] <= victimTlb[victimIdx];
			victimTlb[victimIdx] <= mainTlb[reqSlot];
		end else if (doFill) begin
			mainTlb[fillSlot] <= fillEntry;
			if (mainTlb[fillSlot].valid) begin
				victimTlb[freeSlot] <= mainTlb[fillSlot];
				if (!haveFree) victimPtr <= victimPtr + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || wrBase || wrInval || !dirCacheOn) begin
			for (int i = 0; i < DIR_ENTRIES; i++) dirCache[i] <= '0;
			dirPtr <= '0;
		end else if (state == paging_tlb_pkg::ST_DIRWT && memAck
			&& memData[paging_tlb_pkg::ENT_PRESENT]) begin
			dirCache[dirPtr] <= '{valid: 1'b1, dirIndex: dirIdx, tableBase: memData[31:12]};
			dirPtr <= dirPtr + 1'b1;
		end
	end

	// ****************************************
	// outputs toward core and memory
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			memReq  <= 1'b0;
			memAddr <= paging_tlb_pkg::RST_WORD;
		end else begin
			memReq <= 1'b0;
			if (state == paging_tlb_pkg::ST_DIRREQ && !mainHit && !victimHit && !dirHit) begin
				memReq  <= 1'b1;
				memAddr <= {dirBase[31:12], dirIdx, 2'b00};
			end else if (state == paging_tlb_pkg::ST_PGREQ) begin
				memReq  <= 1'b1;
				memAddr <= {tableBase, tblIdx, 2'b00};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			xlateDone   <= 1'b0;
			xlateResult <= '0;
		end else begin
			xlateDone <= state == paging_tlb_pkg::ST_DONE || state == paging_tlb_pkg::ST_FAULT;
			if (state == paging_tlb_pkg::ST_FAULT) begin
				xlateResult <= '{physAddr: reqAddr, nocache: 1'b0, wthru: 1'b0, fault: 1'b1};
			end else if (state == paging_tlb_pkg::ST_DONE) begin
				if (!pagingOn) begin
					xlateResult <= '{physAddr: reqAddr, nocache: 1'b0, wthru: 1'b0, fault: 1'b0};
				end else begin
					xlateResult.physAddr <= {mainTlb[reqSlot].physPage, reqAddr[11:0]};
					xlateResult.nocache  <= mainTlb[reqSlot].nocache;
					xlateResult.wthru    <= mainTlb[reqSlot].wthru;
					xlateResult.fault    <= !permitted(mainTlb[reqSlot], reqWrite, reqPriv);
				end
			end
		end
	end
endmodule // paging_translation_tlb

`default_nettype wire

// ===== sim/page_memory_model.sv
// model: page-table memory answering walk reads
`timescale 1ns/10ps
`default_nettype none
module page_memory_model (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        memReq,
	input  wire logic [31:0] memAddr,
	output logic             memAck,
	output logic [31:0]      memData
);
	logic [31:0] store [logic [31:0]];
	logic [31:0] pend;
	int          lat = 1;

	task automatic put(input logic [31:0] a, input logic [31:0] d);
		store[a] = d;
	endtask

	initial begin
		memAck = 1'b0;
		memData = 32'h0;
		forever begin
			@(posedge core_clk);
			memAck <= 1'b0;
			// released data toggles so a stale word cannot pass
			memData <= ~memData;
			if (memReq === 1'b1 && sys_rst === 1'b0) begin
				pend = memAddr;
				repeat (lat) @(posedge core_clk);
				memAck <= 1'b1;
				// unwritten words read as absent entries
				memData <= store.exists(pend) ? store[pend] : 32'h0;
			end
		end
	end
endmodule // page_memory_model
`default_nettype wire

// ===== sim/paging_translation_tlb_props.sv
// checker: port-level properties of the paging translation block
`timescale 1ns/10ps
`default_nettype none
module paging_translation_tlb_props (
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic                          pready,
	input  wire logic [31:0]                   prdata,
	input  wire logic                          pslverr,
	input  wire logic                          xlateReq,
	input  wire logic [31:0]                   linearAddr,
	input  wire logic                          isWrite,
	input  wire logic [1:0]                    currentPrivilegeLevel,
	input  wire logic                          xlateDone,
	input  wire paging_tlb_pkg::xlate_result_s xlateResult,
	input  wire logic                          memReq,
	input  wire logic [31:0]                   memAddr,
	input  wire logic                          memAck,
	input  wire logic [31:0]                   memData
);
	logic        busy;
	logic        wasOn;
	logic        xlOn;
	logic        dcOn;
	logic [19:0] dirBase;
	logic [31:0] reqAddr;
	logic [31:0] lastData;
	logic [1:0]  nRd;
	logic        absent;
	wire logic   start = xlateReq && !busy;
	wire logic   apbWr = psel && penable && pready && pwrite;

	// ****************************************
	// shadows of request, control and walk
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy <= 1'b0;
			wasOn <= 1'b0;
			reqAddr <= 32'h0;
		end else if (start) begin
			busy <= 1'b1;
			wasOn <= xlOn;
			reqAddr <= linearAddr;
		end else if (xlateDone) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			xlOn <= 1'b0;
			dcOn <= 1'b0;
			dirBase <= 20'h0;
		end else if (apbWr) begin
			if (paddr == paging_tlb_pkg::OFF_CONTROL)
				xlOn <= pwdata[paging_tlb_pkg::CTRL_PAGING_BIT] && pwdata[paging_tlb_pkg::CTRL_PROT_BIT];
			if (paddr == paging_tlb_pkg::OFF_CONFIG4)
				dcOn <= pwdata[paging_tlb_pkg::CFG4_DIRC_BIT];
			if (paddr == paging_tlb_pkg::OFF_DIR_BASE)
				dirBase <= pwdata[31:12];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || start) begin
			nRd <= 2'h0;
			absent <= 1'b0;
			lastData <= 32'h0;
		end else if (memAck) begin
			nRd <= nRd + 2'h1;
			absent <= absent || !memData[paging_tlb_pkg::ENT_PRESENT];
			lastData <= memData;
		end
	end

	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_setup; psel && !penable; endsequence
	sequence s_start_off; start && !xlOn; endsequence
	sequence s_done_ok; xlateDone && !xlateResult.fault; endsequence

	AST_APB_ANSWER: assert property (s_setup |=> pready)
		else $error("no pready after setup");
	AST_APB_ERR: assert property (psel && penable && pready && paddr[1:0] == 2'h0 |->
		pslverr == (paddr > paging_tlb_pkg::OFF_STATUS)) else $error("pslverr wrong");
	AST_PASSTHRU: assert property (s_start_off |-> ##[1:2]
		(xlateDone && xlateResult.physAddr == reqAddr)) else $error("untranslated address wrong");
	AST_OFF_NO_READ: assert property (busy && !wasOn |-> !memReq)
		else $error("table read with paging off");
	AST_OFFSET: assert property (s_done_ok |-> xlateResult.physAddr[11:0] == reqAddr[11:0])
		else $error("page offset altered");
	AST_DIR_FETCH: assert property (memReq && busy && wasOn && !dcOn && nRd == 2'h0 |->
		memAddr == {dirBase, reqAddr[31:22], 2'b00}) else $error("directory entry address wrong");
	AST_PAGE_FETCH: assert property (memReq && busy && wasOn && !dcOn && nRd == 2'h1 |->
		memAddr == {lastData[31:12], reqAddr[21:12], 2'b00}) else $error("page entry address wrong");
	AST_PHYS: assert property (s_done_ok ##0 wasOn && nRd == 2'h2 |->
		xlateResult.physAddr[31:12] == lastData[31:12]) else $error("frame not from entry");
	AST_ATTR: assert property (s_done_ok ##0 wasOn && nRd == 2'h2 |->
		{xlateResult.nocache, xlateResult.wthru} == lastData[4:3]) else $error("cache bits wrong");
	AST_ABSENT: assert property (xlateDone && absent |-> xlateResult.fault)
		else $error("absent entry not faulted");
endmodule // paging_translation_tlb_props
`default_nettype wire

// ===== sim/paging_translation_tlb_test.sv
// testbench: register, translation and test-register scenarios
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module paging_translation_tlb_test;
	logic                          core_clk = 1'b0;
	logic                          sys_rst = 1'b1;
	logic                          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic                          xlateReq = 1'b0, isWrite = 1'b0;
	logic [7:0]                    paddr = 8'h00;
	logic [31:0]                   pwdata = 32'h0, linearAddr = 32'h0;
	logic [1:0]                    currentPrivilegeLevel = 2'h0;
	logic [31:0]                   prdata, memAddr, memData, rd;
	logic                          pready, pslverr, xlateDone, memReq, memAck, err;
	paging_tlb_pkg::xlate_result_s xlateResult, res;
	int                            mismatches = 0, compares = 0, memReads = 0;
	logic [31:0]                   ctl [3] = '{32'h0, 32'h1, 32'h8000_0000};

	paging_translation_tlb dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .xlateReq(xlateReq), .linearAddr(linearAddr),
		.isWrite(isWrite), .currentPrivilegeLevel(currentPrivilegeLevel),
		.xlateDone(xlateDone), .xlateResult(xlateResult), .memReq(memReq),
		.memAddr(memAddr), .memAck(memAck), .memData(memData));
	page_memory_model mem (.core_clk(core_clk), .sys_rst(sys_rst), .memReq(memReq),
		.memAddr(memAddr), .memAck(memAck), .memData(memData));

	initial forever #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (memReq === 1'b1) memReads++;

	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************
	// access tasks
	// ****************************************
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			mismatches++;
			end_sim;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic xc(input logic [31:0] la, input logic wr, input logic [1:0] pl,
		input logic [31:0] pa, input logic flt, input int reads);
		int n = 0;
		@(posedge core_clk);
		memReads = 0;
		xlateReq <= 1'b1;
		linearAddr <= la;
		isWrite <= wr;
		currentPrivilegeLevel <= pl;
		@(posedge core_clk);
		xlateReq <= 1'b0;
		do begin
			@(posedge core_clk);
			n++;
		end while (xlateDone !== 1'b1 && n < 200);
		if (n >= 200) begin
			mismatches++;
			end_sim;
		end
		res = xlateResult;
		`CHK("fault", flt, res.fault)
		if (!flt) `CHK("phys", pa, res.physAddr)
		`CHK("reads", reads, memReads)
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 2; i < 5; i++) begin
			apb(8'(i * 4), 1'b0, 32'h0);
			`CHK("reset word", paging_tlb_pkg::RST_WORD, rd)
		end
		apb(paging_tlb_pkg::OFF_STATUS, 1'b0, 32'h0);
		`CHK("status idle", 32'(paging_tlb_pkg::ST_IDLE), rd)
		apb(8'h40, 1'b1, 32'hffff_ffff);
		`CHK("unmapped wr", 1'b1, err)
		apb(8'h40, 1'b0, 32'h0);
		`CHK("unmapped rd", 33'h1_0000_0000, {err, rd})
		foreach (ctl[i]) begin
			apb(paging_tlb_pkg::OFF_CONTROL, 1'b1, ctl[i]);
			xc(32'h0040_3abc, 1'b1, 2'h3, 32'h0040_3abc, 1'b0, 0);
		end
		mem.put(32'h0010_0004, 32'h0020_0f87);
		mem.put(32'h0020_000c, 32'h1234_5f9f);
		mem.put(32'h0010_0008, 32'h0030_0007);
		mem.put(32'h0030_000c, 32'h5555_5001);
		mem.put(32'h0030_0010, 32'h6666_6003);
		mem.put(32'h0020_0014, 32'h7777_7003);
		apb(paging_tlb_pkg::OFF_DIR_BASE, 1'b1, 32'h0010_0000);
		apb(paging_tlb_pkg::OFF_CONTROL, 1'b1, 32'h8000_0001);
		mem.lat = 6;
		xc(32'h0040_3abc, 1'b0, 2'h3, 32'h1234_5abc, 1'b0, 2);
		`CHK("cache bits", 2'b11, {res.nocache, res.wthru})
		mem.lat = 1;
		xc(32'h0040_3abc, 1'b1, 2'h3, 32'h1234_5abc, 1'b0, 0);
		xc(32'h0080_3abc, 1'b0, 2'h0, 32'h5555_5abc, 1'b0, 2);
		xc(32'h0040_3abc, 1'b0, 2'h3, 32'h1234_5abc, 1'b0, 0);
		xc(32'h0080_3abc, 1'b0, 2'h3, 32'h0, 1'b1, 0);
		xc(32'h0080_3abc, 1'b1, 2'h0, 32'h0, 1'b1, 0);
		apb(paging_tlb_pkg::OFF_TEST_COMMAND, 1'b1, 32'h0080_3019);
		apb(paging_tlb_pkg::OFF_TEST_DATA, 1'b0, 32'h0);
		`CHK("main flags", 3'b010, rd[5:3])
		`CHK("main data", {20'h55555, 2'b00}, rd[31:10])
		apb(paging_tlb_pkg::OFF_TEST_COMMAND, 1'b1, 32'h0080_3011);
		apb(paging_tlb_pkg::OFF_TEST_DATA, 1'b0, 32'h0);
		`CHK("pair miss", 3'b000, rd[5:3])
		apb(paging_tlb_pkg::OFF_TEST_COMMAND, 1'b1, 32'h0040_3019);
		apb(paging_tlb_pkg::OFF_TEST_DATA, 1'b0, 32'h0);
		`CHK("victim flags", 3'b100, rd[5:3])
		`CHK("victim data", {20'h12345, 2'b11, 3'b000}, rd[31:7])
		for (int c = 0; c < 2; c++) begin
			apb(paging_tlb_pkg::OFF_TEST_DATA, 1'b1, 32'habcd_e800);
			apb(paging_tlb_pkg::OFF_TEST_COMMAND, 1'b1, 32'h0765_4d50 + c * 32'h1002);
			xc(32'h0765_4123 + c * 32'h1000, 1'b1, 2'h3, 32'habcd_e123, 1'b0, 0);
			`CHK("written bits", 2'b10, {res.nocache, res.wthru})
		end
		apb(paging_tlb_pkg::OFF_DIR_BASE, 1'b1, 32'h0010_0000);
		xc(32'h0765_4123, 1'b0, 2'h0, 32'h0, 1'b1, 1);
		xc(32'h0080_3abc, 1'b0, 2'h0, 32'h5555_5abc, 1'b0, 2);
		apb(paging_tlb_pkg::OFF_INVALIDATE, 1'b1, 32'h0080_3abc);
		xc(32'h0080_3abc, 1'b0, 2'h0, 32'h5555_5abc, 1'b0, 2);
		xc(32'h0080_4000, 1'b0, 2'h0, 32'h6666_6000, 1'b0, 2);
		apb(paging_tlb_pkg::OFF_CONFIG4, 1'b1, 32'h0000_0010);
		xc(32'h0040_3abc, 1'b0, 2'h3, 32'h1234_5abc, 1'b0, 2);
		xc(32'h0040_5000, 1'b0, 2'h0, 32'h7777_7000, 1'b0, 1);
		apb(paging_tlb_pkg::OFF_INVALIDATE, 1'b1, 32'h0040_5000);
		xc(32'h0040_5000, 1'b0, 2'h0, 32'h7777_7000, 1'b0, 2);
		end_sim;
	end
endmodule // paging_translation_tlb_test

bind paging_translation_tlb paging_translation_tlb_props props (.core_clk(core_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.xlateReq(xlateReq), .linearAddr(linearAddr), .isWrite(isWrite),
	.currentPrivilegeLevel(currentPrivilegeLevel), .xlateDone(xlateDone),
	.xlateResult(xlateResult), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
	.memData(memData));
`default_nettype wire
